// ---- pkg/cswps_pkg.sv ----
package cswps_pkg;
    // register addresses on the special function bus
    localparam logic [7:0] CSWPS_ADDR_AUX = 8'ha3;
    localparam logic [7:0] CSWPS_ADDR_STAT = 8'hd0;
    // status word field positions
    localparam int CSWPS_CARRY_BIT = 7;
    localparam int CSWPS_HALF_BIT = 6;
    localparam int CSWPS_USER0_BIT = 5;
    localparam int CSWPS_BANK_HI_BIT = 4;
    localparam int CSWPS_BANK_LO_BIT = 3;
    localparam int CSWPS_WRAP_BIT = 2;
    localparam int CSWPS_USER1_BIT = 1;
    localparam int CSWPS_ODD_BIT = 0;
    // pointer select field position in the aux register
    localparam int CSWPS_PTR_SEL_BIT = 0;
    // bank base is bank number times eight registers
    localparam int CSWPS_BANK_SHIFT = 3;
    // reset values
    localparam logic [7:0] CSWPS_STAT_RST = 8'h00;
    localparam logic [7:0] CSWPS_AUX_RST = 8'h00;
    localparam logic [15:0] CSWPS_DP_RST = 16'h0000;
    localparam logic [7:0] CSWPS_RD_NONE = 8'h00;
endpackage

// ---- src/cswps_top.sv ----
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module cswps_top
    import cswps_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST,
    // special function register port
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // alu flag update, operands in add form
    input wire logic ALU_UPD,
    input wire logic [7:0] ALU_A,
    input wire logic [7:0] ALU_B,
    input wire logic ALU_CIN,
    // single-bit operation result into carry
    input wire logic BIT_WE,
    input wire logic BIT_VAL,
    // accumulator contents for parity
    input wire logic [7:0] ACC,
    // data pointer operations
    input wire logic DP_LOAD,
    input wire logic DP_INC,
    input wire logic [15:0] DP_WDATA,
    output logic [15:0] DP_VALUE,
    // flag and bank views for the core
    output logic CARRY,
    output logic PARITY,
    output logic [1:0] BANK_SEL,
    output logic [7:0] BANK_BASE
);
    // status word fields
    logic carry_flag;
    logic half_carry_flag;
    logic user_flag_zero;
    logic bank_sel_hi;
    logic bank_sel_lo;
    logic signed_wrap_flag;
    logic user_flag_one;
    // pointer select and the two pointers
    logic pointer_choice;
    logic [15:0] data_pointer_reg;
    logic [15:0] alt_data_pointer;
    // alu carry chain taps
    logic [7:0] sum_mid;
    logic [8:0] sum_all;
    logic carry_six;
    logic carry_sev;
    // parity of the live accumulator
    logic ones_odd_flag;
    // decoded writes
    logic wr_stat;
    logic wr_aux;
    logic [7:0] stat_view;
    logic [7:0] next_rdata;

    // carry taps: into bit seven and out of bit seven
    always_comb
    begin
        sum_mid = {1'b0, ALU_A[6:0]} + {1'b0, ALU_B[6:0]} + {7'h00, ALU_CIN};
        sum_all = {1'b0, ALU_A} + {1'b0, ALU_B} + {8'h00, ALU_CIN};
        carry_six = sum_mid[7];
        carry_sev = sum_all[8];
    end

    assign wr_stat = WR && (ADDR == CSWPS_ADDR_STAT);
    assign wr_aux = WR && (ADDR == CSWPS_ADDR_AUX);

    // carry: alu wins over bit op, bit op over software
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            carry_flag <= CSWPS_STAT_RST[CSWPS_CARRY_BIT];
        end
        else if (ALU_UPD)
        begin
            carry_flag <= carry_sev;
        end
        else if (BIT_WE)
        begin
            carry_flag <= BIT_VAL;
        end
        else if (wr_stat)
        begin
            carry_flag <= WDATA[CSWPS_CARRY_BIT];
        end
    end

    // half carry and overflow follow every alu update
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            half_carry_flag <= CSWPS_STAT_RST[CSWPS_HALF_BIT];
            signed_wrap_flag <= CSWPS_STAT_RST[CSWPS_WRAP_BIT];
        end
        // hardware update wins over a same-cycle software write
        else if (ALU_UPD)
        begin
            // the top nibble carries out where bit seven does, so after an
            // alu update this flag matches carry; status writes and bit ops split them
            // top nibble carry
            half_carry_flag <= carry_sev;
            signed_wrap_flag <= carry_six ^ carry_sev;
        end
        else if (wr_stat)
        begin
            half_carry_flag <= WDATA[CSWPS_HALF_BIT];
            signed_wrap_flag <= WDATA[CSWPS_WRAP_BIT];
        end
    end

    // user flags: software only, no hardware effect
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            user_flag_zero <= CSWPS_STAT_RST[CSWPS_USER0_BIT];
            user_flag_one <= CSWPS_STAT_RST[CSWPS_USER1_BIT];
        end
        else if (wr_stat)
        begin
            user_flag_zero <= WDATA[CSWPS_USER0_BIT];
            user_flag_one <= WDATA[CSWPS_USER1_BIT];
        end
    end

    // bank select bits, software written
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            bank_sel_hi <= CSWPS_STAT_RST[CSWPS_BANK_HI_BIT];
            bank_sel_lo <= CSWPS_STAT_RST[CSWPS_BANK_LO_BIT];
        end
        else if (wr_stat)
        begin
            bank_sel_hi <= WDATA[CSWPS_BANK_HI_BIT];
            bank_sel_lo <= WDATA[CSWPS_BANK_LO_BIT];
        end
    end

    assign BANK_SEL = {bank_sel_hi, bank_sel_lo};
    assign BANK_BASE = {3'b000, bank_sel_hi, bank_sel_lo, 3'b000};

    assign ones_odd_flag = ^ACC;
    assign PARITY = ones_odd_flag;
    assign CARRY = carry_flag;

    // pointer select; reserved aux bits are not stored
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            pointer_choice <= CSWPS_AUX_RST[CSWPS_PTR_SEL_BIT];
        end
        else if (wr_aux)
        begin
            pointer_choice <= WDATA[CSWPS_PTR_SEL_BIT];
        end
    end

    // the two pointers; only the selected one moves
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            data_pointer_reg <= CSWPS_DP_RST;
            alt_data_pointer <= CSWPS_DP_RST;
        end
        else if (!pointer_choice)
        begin
            if (DP_LOAD)
            begin
                data_pointer_reg <= DP_WDATA;
            end
            else if (DP_INC)
            begin
                data_pointer_reg <= data_pointer_reg + 16'h0001;
            end
        end
        else
        begin
            if (DP_LOAD)
            begin
                alt_data_pointer <= DP_WDATA;
            end
            else if (DP_INC)
            begin
                alt_data_pointer <= alt_data_pointer + 16'h0001;
            end
        end
    end

    assign DP_VALUE = pointer_choice ? alt_data_pointer : data_pointer_reg;

    // status word as software sees it
    always_comb
    begin
        stat_view = {carry_flag, half_carry_flag, user_flag_zero, bank_sel_hi,
            bank_sel_lo, signed_wrap_flag, user_flag_one, ones_odd_flag};
        next_rdata = CSWPS_RD_NONE;
        if (RD)
        begin
            case (ADDR)
                CSWPS_ADDR_STAT: next_rdata = stat_view;
                // reserved bits read as zero
                CSWPS_ADDR_AUX: next_rdata = {7'h00, pointer_choice};
                default: next_rdata = CSWPS_RD_NONE;
            endcase
        end
    end

    // read data stand one cycle after the strobe
    always_ff @(posedge CLK_SYS)
    begin
        if (RST)
        begin
            RDATA <= CSWPS_RD_NONE;
        end
        else
        begin
            RDATA <= next_rdata;
        end
    end

    // checks on the flag and pointer behaviour
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // carry follows the alu carry out
    property p_carry_alu;
        ALU_UPD |=> CARRY == $past(carry_sev);
    endproperty
    a_carry_alu: assert property (p_carry_alu)
        else $error("carry does not match alu carry out");

    // bit op loads carry when no alu update
    property p_carry_bit;
        (BIT_WE && !ALU_UPD) |=> CARRY == $past(BIT_VAL);
    endproperty
    a_carry_bit: assert property (p_carry_bit)
        else $error("bit operation did not load carry");

    // half carry from the top nibble carry out
    property p_half_carry;
        ALU_UPD |=> half_carry_flag == $past(sum_all[8]);
    endproperty
    a_half_carry: assert property (p_half_carry)
        else $error("half carry wrong after alu update");

    // flag zero holds without a status write
    property p_flag_zero;
        !wr_stat |=> $stable(user_flag_zero);
    endproperty
    a_flag_zero: assert property (p_flag_zero)
        else $error("user flag zero changed without write");

    // bank base tracks a written bank number
    property p_bank;
        wr_stat |=> BANK_BASE == {3'b000, $past(WDATA[CSWPS_BANK_HI_BIT]),
            $past(WDATA[CSWPS_BANK_LO_BIT]), 3'b000};
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank base does not match written bank");

    // overflow is carry six xor carry seven
    property p_overflow;
        ALU_UPD |=> signed_wrap_flag == ($past(sum_mid[7]) ^ $past(sum_all[8]));
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow flag wrong after alu update");

    // flag one takes the written value
    property p_flag_one;
        wr_stat |=> user_flag_one == $past(WDATA[CSWPS_USER1_BIT]);
    endproperty
    a_flag_one: assert property (p_flag_one)
        else $error("user flag one did not take write");

    // status read shows accumulator parity of the read cycle
    property p_parity_read;
        (RD && ADDR == CSWPS_ADDR_STAT) |=> RDATA[0] == $past(^ACC);
    endproperty
    a_parity_read: assert property (p_parity_read)
        else $error("parity bit read does not match accumulator");

    // a written parity value does not stick
    property p_parity_write;
        wr_stat ##1 (RD && ADDR == CSWPS_ADDR_STAT) |=> RDATA[0] == $past(^ACC);
    endproperty
    a_parity_write: assert property (p_parity_write)
        else $error("parity bit kept a software value");

    // a load with pointer select clear lands in data_pointer_reg only
    property p_dp_route;
        (DP_LOAD && !pointer_choice) |=> data_pointer_reg == $past(DP_WDATA)
            && alt_data_pointer == $past(alt_data_pointer);
    endproperty
    a_dp_route: assert property (p_dp_route)
        else $error("pointer load went to the wrong pointer");

    // reserved aux bits read as zero
    property p_aux_read;
        (RD && ADDR == CSWPS_ADDR_AUX) |=> RDATA[7:1] == 7'h00;
    endproperty
    a_aux_read: assert property (p_aux_read)
        else $error("reserved aux bits read nonzero");
endmodule
`default_nettype wire

// ---- tb/cswps_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module cswps_top_tb_top
    import cswps_pkg::*;
;
    // bench-driven inputs, all defined from time zero
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, acc = 8'h00, alu_a = 8'h00, alu_b = 8'h00;
    logic wr = 1'b0, rd = 1'b0, alu_upd = 1'b0, alu_cin = 1'b0, bit_we = 1'b0, bit_val = 1'b0;
    logic dp_load = 1'b0, dp_inc = 1'b0;
    logic [15:0] dp_wdata = 16'h0000;
    // design outputs
    logic [7:0] rdata, bank_base;
    logic [15:0] dp_value;
    logic carry, parity;
    logic [1:0] bank_sel;
    // scoreboard state; stat_m mirrors the software view of the status word
    int bad_count = 0;
    int checks_done = 0;
    logic [7:0] stat_m = 8'h00;
    logic [7:0] exp_q[$];
    logic rd_d = 1'b0;

    always #5 clk_sys = ~clk_sys;

    cswps_top DUT (.CLK_SYS(clk_sys), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .ALU_UPD(alu_upd), .ALU_A(alu_a), .ALU_B(alu_b), .ALU_CIN(alu_cin),
        .BIT_WE(bit_we), .BIT_VAL(bit_val), .ACC(acc), .DP_LOAD(dp_load), .DP_INC(dp_inc),
        .DP_WDATA(dp_wdata), .DP_VALUE(dp_value), .CARRY(carry), .PARITY(parity),
        .BANK_SEL(bank_sel), .BANK_BASE(bank_base));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        if (exp_q.size() != 0)
            bad_count++;
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // read data counts only in the cycle after the strobe, zero in every other cycle
    always @(posedge clk_sys) rd_d <= rd;
    always @(negedge clk_sys)
    begin
        if (rd_d !== 1'b1)
            check({8'h00, rdata}, {8'h00, CSWPS_RD_NONE});
        else if (exp_q.size() == 0)
            check({8'h00, rdata}, 16'hdead);
        else
            check({8'h00, rdata}, {8'h00, exp_q.pop_front()});
    end

    // one-cycle write; the model ignores unmapped addresses like the slave does
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
        if (a == CSWPS_ADDR_STAT)
            stat_m = d;
    endtask

    // one-cycle read; status bit 0 is always the live parity of acc
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back((a == CSWPS_ADDR_STAT) ? {stat_m[7:1], ^acc} : e);
        @(posedge clk_sys);
        rd <= 1'b0;
    endtask

    // alu update, optionally racing a status write that must lose the arithmetic flags
    task automatic alu_op(input logic [7:0] a, input logic [7:0] b, input logic c, input logic w);
        logic [8:0] s;
        logic [7:0] l;
        s = {1'b0, a} + {1'b0, b} + {8'h00, c};
        l = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, c};
        @(posedge clk_sys);
        alu_a <= a;
        alu_b <= b;
        alu_cin <= c;
        alu_upd <= 1'b1;
        acc <= s[7:0];
        addr <= CSWPS_ADDR_STAT;
        wdata <= 8'hfe;
        wr <= w;
        @(posedge clk_sys);
        alu_upd <= 1'b0;
        wr <= 1'b0;
        if (w)
            stat_m = 8'hfe;
        stat_m[CSWPS_CARRY_BIT] = s[8];
        // half carry is the carry out of the top nibble
        stat_m[CSWPS_HALF_BIT] = s[8];
        stat_m[CSWPS_WRAP_BIT] = s[8] ^ l[7];
    endtask

    task automatic dp_op(input logic ld, input logic inc, input logic [15:0] d,
        input logic [15:0] e);
        @(posedge clk_sys);
        dp_load <= ld;
        dp_inc <= inc;
        dp_wdata <= d;
        @(posedge clk_sys);
        dp_load <= 1'b0;
        dp_inc <= 1'b0;
        #1 check(dp_value, e);
    endtask

    // a hang is cut short here and counted as a mismatch
    initial
    begin
        #200000;
        bad_count++;
        summarize();
    end

    initial
    begin
        logic [7:0] v;
        void'($urandom(79));
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1 check(dp_value, CSWPS_DP_RST);
        check({8'h00, bank_base}, 16'h0000);
        rd_reg(CSWPS_ADDR_AUX, CSWPS_AUX_RST);
        rd_reg(8'h55, CSWPS_RD_NONE);
        rd_reg(CSWPS_ADDR_STAT, 8'h00);
        // every bank code, user flags toggled, parity bit written high in vain
        for (int b = 0; b < 4; b++)
        begin
            v = 8'h01;
            v[CSWPS_BANK_HI_BIT] = b[1];
            v[CSWPS_BANK_LO_BIT] = b[0];
            v[CSWPS_USER0_BIT] = b[0];
            v[CSWPS_USER1_BIT] = b[1];
            wr_reg(CSWPS_ADDR_STAT, v);
            #1 check({14'h0000, bank_sel}, {14'h0000, b[1:0]});
            check({8'h00, bank_base}, {11'h000, b[1:0], 3'b000});
            wr_reg(8'h55, 8'hff);
            rd_reg(CSWPS_ADDR_STAT, 8'h00);
        end
        // status write then read with no gap; the written parity bit must not stick
        @(posedge clk_sys);
        addr <= CSWPS_ADDR_STAT;
        wdata <= 8'h25;
        wr <= 1'b1;
        stat_m = 8'h25;
        exp_q.push_back({stat_m[7:1], ^acc});
        @(posedge clk_sys);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        // corner sum, then random sums with flags read back
        alu_op(8'hff, 8'h01, 1'b0, 1'b0);
        rd_reg(CSWPS_ADDR_STAT, 8'h00);
        for (int k = 0; k < 24; k++)
        begin
            alu_op(8'($urandom), 8'($urandom), 1'($urandom), 1'b0);
            #1 check({15'h0000, parity}, {15'h0000, ^acc});
            rd_reg(CSWPS_ADDR_STAT, 8'h00);
        end
        // hardware flag update wins over a same-cycle status write
        alu_op(8'h01, 8'h01, 1'b0, 1'b1);
        rd_reg(CSWPS_ADDR_STAT, 8'h00);
        // single-bit results land in carry
        for (int k = 1; k >= 0; k--)
        begin
            @(posedge clk_sys);
            bit_val <= k[0];
            bit_we <= 1'b1;
            @(posedge clk_sys);
            bit_we <= 1'b0;
            stat_m[CSWPS_CARRY_BIT] = k[0];
            #1 check({15'h0000, carry}, {15'h0000, k[0]});
        end
        // pointer routing; reserved aux bits read back as zero
        dp_op(1'b1, 1'b0, 16'h1234, 16'h1234);
        wr_reg(CSWPS_ADDR_AUX, 8'hff);
        #1 check(dp_value, CSWPS_DP_RST);
        rd_reg(CSWPS_ADDR_AUX, 8'h01);
        dp_op(1'b1, 1'b0, 16'habcd, 16'habcd);
        dp_op(1'b0, 1'b1, 16'h0000, 16'habce);
        dp_op(1'b1, 1'b1, 16'hffff, 16'hffff);
        dp_op(1'b0, 1'b1, 16'h0000, 16'h0000);
        wr_reg(CSWPS_ADDR_AUX, 8'h00);
        #1 check(dp_value, 16'h1234);
        // mid-run reset must clear flags, bank and the live pointer
        wr_reg(CSWPS_ADDR_STAT, 8'hfa);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        stat_m = CSWPS_STAT_RST;
        #1 check(dp_value, CSWPS_DP_RST);
        check({15'h0000, carry}, 16'h0000);
        check({8'h00, bank_base}, 16'h0000);
        rd_reg(CSWPS_ADDR_STAT, 8'h00);
        repeat (3) @(posedge clk_sys);
        summarize();
    end
endmodule
`default_nettype wire
